// [inc/pti_pkg.sv]
package pti_pkg;

  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte addresses
  localparam logic [7:0] CTRL_OFFSET       = 8'h1c;
  localparam logic [7:0] EVT_STATUS_OFFSET = 8'h20;
  localparam logic [7:0] EVT_MASK_OFFSET   = 8'h24;

  // control register field positions
  localparam int PEND_BIT = 7;
  localparam int RATE_MSB = 6;
  localparam int RATE_LSB = 4;
  localparam int ACK_BIT  = 3;
  localparam int IE_BIT   = 2;
  localparam int EN_BIT   = 1;

  // event status and mask field position
  localparam int EVT_TICK_BIT = 0;

  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic       EVT_RESET  = 1'b0;

  // divider structure
  localparam int CHAIN_STAGES = 15;
  localparam int PRESCALE_DIV = 128;

  typedef logic [2:0] pti_rate_t;

  // chain bit whose rising edge marks the event for each rate code;
  // the full period is twice that bit's weight
  localparam int TAP_BIT [8] = '{14, 12, 10, 6, 5, 4, 3, 2};

endpackage

// [rtl/pti_sync.sv]
`timescale 1ns/1ns
module pti_sync
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             clk,  // system clock
  input  wire logic             rst,  // synchronous reset, active high
  input  wire logic [WIDTH-1:0] d,    // asynchronous inputs
  output logic      [WIDTH-1:0] q     // synchronised copies
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] q_reg;
  logic [WIDTH-1:0] q_next;

  // the first stage feeds only the second stage
  always_comb
  begin
    meta_next = d;
    q_next    = meta_reg;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_reg <= '0;
      q_reg    <= '0;
    end
    else
    begin
      meta_reg <= meta_next;
      q_reg    <= q_next;
    end
  end

  assign q = q_reg;

endmodule

// [rtl/pti_divider.sv]
`timescale 1ns/1ns
module pti_divider
#(
  parameter int STAGES  = pti_pkg::CHAIN_STAGES,
  parameter int PRE_DIV = pti_pkg::PRESCALE_DIV
)
(
  input  wire logic              clk,       // system clock
  input  wire logic              rst,       // synchronous reset
  input  wire logic              src_tick,  // one oscillator edge
  input  wire logic              run,       // chain may advance
  input  wire logic              clear,     // hold chain at zero
  input  wire logic              extra_sel, // insert the extra prescale
  input  wire pti_pkg::pti_rate_t rate,     // tap select
  output logic                   rollover   // one-cycle event pulse
);
  import pti_pkg::*;

  localparam int PRE_W = $clog2(PRE_DIV);

  logic [STAGES-1:0] chain_reg;
  logic [STAGES-1:0] chain_next;
  logic [PRE_W-1:0]  pre_reg;
  logic [PRE_W-1:0]  pre_next;
  logic              rollover_reg;
  logic              rollover_next;
  logic              pre_wrap;
  logic              step;
  logic              tap_rise;
  logic [STAGES-1:0] low_mask;
  logic [STAGES-1:0] tap_mask;
  int                tap;

  always_comb
  begin
    tap      = TAP_BIT[rate];
    low_mask = STAGES'((64'd1 << tap) - 64'd1);
    tap_mask = STAGES'(64'd1 << tap);
    pre_wrap = (pre_reg == PRE_W'(PRE_DIV - 1));
    step     = src_tick & run & (~extra_sel | pre_wrap);
    // event on tap rising edge
    // rising edge of the tap bit: half period after a restart, then
    // exactly one full period apart
    tap_rise = step & ((chain_reg & low_mask) == low_mask)
               & ((chain_reg & tap_mask) == '0);
    pre_next      = pre_reg;
    chain_next    = chain_reg;
    rollover_next = 1'b0;
    if (clear)
    begin
      pre_next   = '0;
      chain_next = '0;
    end
    else
    begin
      if (src_tick & run & extra_sel)
      begin
        pre_next = pre_wrap ? '0 : pre_reg + PRE_W'(1);
      end
      if (step)
      begin
        chain_next = chain_reg + STAGES'(1);
      end
      rollover_next = tap_rise;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pre_reg      <= '0;
      chain_reg    <= '0;
      rollover_reg <= 1'b0;
    end
    else
    begin
      pre_reg      <= pre_next;
      chain_reg    <= chain_next;
      rollover_reg <= rollover_next;
    end
  end

  assign rollover = rollover_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_clear_zero;
    clear |=> (chain_reg == '0) && !rollover_reg;
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("chain not held at zero while disabled");

  property p_event_position;
    rollover_reg && $stable(rate)
      |-> ((chain_reg & tap_mask) != '0) && ((chain_reg & low_mask) == '0);
  endproperty
  a_event_position: assert property (p_event_position)
    else $error("event not at the tap rising edge");

endmodule

// [rtl/pti_top.sv]
`timescale 1ns/1ns
module pti_top
(
  input  wire logic                        MCLK,    // system clock
  input  wire logic                        RST,     // sync reset, high
  input  wire logic                        PSEL,    // apb select
  input  wire logic                        PENABLE, // apb access phase
  input  wire logic                        PWRITE,  // apb direction
  input  wire logic [pti_pkg::ADDR_W-1:0]  PADDR,   // apb byte address
  input  wire logic [pti_pkg::DATA_W-1:0]  PWDATA,  // apb write data
  input  wire logic [3:0]                  PSTRB,   // apb byte strobes
  output logic      [pti_pkg::DATA_W-1:0]  PRDATA,  // apb read data
  output logic                             PREADY,  // apb ready
  output logic                             PSLVERR, // apb error
  input  wire logic                        OSC_CLK_IN,      // oscillator
  input  wire logic                        EXTRA_PRESCALE_SELECT, // /128
  input  wire logic                        OSCILLATOR_RUNS_IN_STOP, // opt
  input  wire logic                        WAIT_MODE,   // cpu in wait
  input  wire logic                        STOP_MODE,   // cpu in stop
  output logic                             IRQ,         // level request
  output logic                             STOP_WAKEUP  // pulse in stop
);
  import pti_pkg::*;

  logic [4:0]  sync_in;
  logic [4:0]  sync_out;
  logic        osc_s;
  logic        extra_s;
  logic        osc_stop_s;
  logic        wait_s;
  logic        stop_s;
  logic        osc_prev_reg;
  logic        osc_prev_next;
  logic        src_tick;
  logic        chain_active;
  logic        bus_blocked;
  logic        rollover;

  logic        pend_reg;
  logic        pend_next;
  pti_rate_t   rate_reg;
  pti_rate_t   rate_next;
  logic        ie_reg;
  logic        ie_next;
  logic        en_reg;
  logic        en_next;
  logic        stat_reg;
  logic        stat_next;
  logic        mask_reg;
  logic        mask_next;
  logic [DATA_W-1:0] prdata_reg;
  logic [DATA_W-1:0] prdata_next;
  logic        wake_reg;
  logic        wake_next;

  logic        apb_setup;
  logic        apb_access;
  logic        sel_ctrl;
  logic        sel_stat;
  logic        sel_mask;
  logic        mapped;
  logic        err_now;
  logic        wr_ok;
  logic        wr_ctrl;
  logic        ack_wr;
  logic        stat_clr;
  logic [7:0]  ctrl_view;

  // all external levels pass two flops before use
  assign sync_in = {STOP_MODE, WAIT_MODE, OSCILLATOR_RUNS_IN_STOP,
                    EXTRA_PRESCALE_SELECT, OSC_CLK_IN};

  pti_sync #(
    .WIDTH (5)
  ) u_sync (
    .clk (MCLK),
    .rst (RST),
    .d   (sync_in),
    .q   (sync_out)
  );

  assign osc_s      = sync_out[0];
  assign extra_s    = sync_out[1];
  assign osc_stop_s = sync_out[2];
  assign wait_s     = sync_out[3];
  assign stop_s     = sync_out[4];

  // oscillator must stay below half of MCLK for the edge to be seen
  assign osc_prev_next = osc_s;
  assign src_tick      = osc_s & ~osc_prev_reg;

  assign chain_active = ~stop_s | osc_stop_s;

  assign bus_blocked = wait_s | stop_s;

  // rate assumed stable while enabled
  // a rate change while running only moves the tap; no guard is built
  pti_divider #(
    .STAGES  (CHAIN_STAGES),
    .PRE_DIV (PRESCALE_DIV)
  ) u_div (
    .clk       (MCLK),
    .rst       (RST),
    .src_tick  (src_tick),
    .run       (en_reg & chain_active),
    .clear     (~en_reg),
    .extra_sel (extra_s),
    .rate      (rate_reg),
    .rollover  (rollover)
  );

  // apb decode; zero wait states
  assign apb_setup  = PSEL & ~PENABLE;
  assign apb_access = PSEL & PENABLE;
  assign sel_ctrl   = (PADDR == CTRL_OFFSET);
  assign sel_stat   = (PADDR == EVT_STATUS_OFFSET);
  assign sel_mask   = (PADDR == EVT_MASK_OFFSET);
  assign mapped     = sel_ctrl | sel_stat | sel_mask;
  assign err_now    = ~mapped | (sel_ctrl & bus_blocked);
  assign wr_ok      = apb_access & PWRITE & ~err_now & PSTRB[0];
  assign wr_ctrl    = wr_ok & sel_ctrl;
  assign ack_wr     = wr_ctrl & PWDATA[ACK_BIT];
  assign stat_clr   = wr_ok & sel_stat & PWDATA[EVT_TICK_BIT];

  // control register layout
  // acknowledge and reserved bits always read zero
  always_comb
  begin
    ctrl_view                   = CTRL_RESET;
    ctrl_view[PEND_BIT]         = pend_reg;
    ctrl_view[RATE_MSB:RATE_LSB] = rate_reg;
    ctrl_view[IE_BIT]           = ie_reg;
    ctrl_view[EN_BIT]           = en_reg;
  end

  always_comb
  begin
    rate_next = rate_reg;
    ie_next   = ie_reg;
    en_next   = en_reg;
    mask_next = mask_reg;
    if (wr_ctrl)
    begin
      rate_next = PWDATA[RATE_MSB:RATE_LSB];
      ie_next   = PWDATA[IE_BIT];
      en_next   = PWDATA[EN_BIT];
    end
    if (wr_ok & sel_mask)
    begin
      mask_next = PWDATA[EVT_TICK_BIT];
    end
    pend_next = rollover | (pend_reg & ~ack_wr);
    stat_next = rollover | (stat_reg & ~stat_clr);
    wake_next = rollover & stop_s;
  end

  // read data is captured in the setup phase and held through access
  always_comb
  begin
    prdata_next = prdata_reg;
    if (apb_setup & ~PWRITE)
    begin
      prdata_next = '0;
      if (sel_ctrl & ~bus_blocked)
      begin
        prdata_next[7:0] = ctrl_view;
      end
      else if (sel_stat)
      begin
        prdata_next[EVT_TICK_BIT] = stat_reg;
      end
      else if (sel_mask)
      begin
        prdata_next[EVT_TICK_BIT] = mask_reg;
      end
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      osc_prev_reg <= 1'b0;
      pend_reg     <= CTRL_RESET[PEND_BIT];
      rate_reg     <= CTRL_RESET[RATE_MSB:RATE_LSB];
      ie_reg       <= CTRL_RESET[IE_BIT];
      en_reg       <= CTRL_RESET[EN_BIT];
      stat_reg     <= EVT_RESET;
      mask_reg     <= EVT_RESET;
      prdata_reg   <= '0;
      wake_reg     <= 1'b0;
    end
    else
    begin
      osc_prev_reg <= osc_prev_next;
      pend_reg     <= pend_next;
      rate_reg     <= rate_next;
      ie_reg       <= ie_next;
      en_reg       <= en_next;
      stat_reg     <= stat_next;
      mask_reg     <= mask_next;
      prdata_reg   <= prdata_next;
      wake_reg     <= wake_next;
    end
  end

  assign PRDATA      = prdata_reg;
  assign PREADY      = 1'b1;
  assign PSLVERR     = apb_access & err_now;
  assign STOP_WAKEUP = wake_reg;

  assign IRQ = (pend_reg & ie_reg) | (stat_reg & mask_reg);

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  property p_pend_set;
    rollover |=> pend_reg;
  endproperty
  a_pend_set: assert property (p_pend_set)
    else $error("rollover did not set pending flag");

  property p_ack_clear;
    ack_wr && !rollover |=> !pend_reg;
  endproperty
  a_ack_clear: assert property (p_ack_clear)
    else $error("acknowledge did not clear pending flag");

  property p_ack_zero_keeps;
    wr_ctrl && !PWDATA[ACK_BIT] && pend_reg |=> pend_reg;
  endproperty
  a_ack_zero_keeps: assert property (p_ack_zero_keeps)
    else $error("writing zero to acknowledge changed the flag");

  property p_ack_reads_zero;
    apb_access && !PWRITE && sel_ctrl |-> !PRDATA[ACK_BIT] && !PRDATA[0];
  endproperty
  a_ack_reads_zero: assert property (p_ack_reads_zero)
    else $error("acknowledge or reserved bit read as one");

  property p_irq_level;
    pend_reg && ie_reg |-> IRQ;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("pending and enabled but no request");

  sequence s_acked;
    ack_wr && !rollover && !(stat_reg && mask_reg) && !stat_clr;
  endsequence

  property p_irq_drops;
    s_acked ##1 !rollover |-> !IRQ || (stat_reg && mask_reg);
  endproperty
  a_irq_drops: assert property (p_irq_drops)
    else $error("request held after acknowledge");

  property p_blocked;
    apb_access && PWRITE && sel_ctrl && bus_blocked
      |-> PSLVERR ##1 (rate_reg == $past(rate_reg))
          && (en_reg == $past(en_reg)) && (ie_reg == $past(ie_reg));
  endproperty
  a_blocked: assert property (p_blocked)
    else $error("control written while in a low power mode");

  sequence s_stop_idle;
    (stop_s && !osc_stop_s) [*2];
  endsequence

  property p_stop_idle;
    s_stop_idle |-> !rollover;
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("chain advanced in stop without oscillator");

  property p_layout;
    wr_ctrl |=> (rate_reg == $past(PWDATA[RATE_MSB:RATE_LSB]))
      && (ie_reg == $past(PWDATA[IE_BIT]))
      && (en_reg == $past(PWDATA[EN_BIT]));
  endproperty
  a_layout: assert property (p_layout)
    else $error("control fields not stored at their positions");

  property p_reset_zero;
    $past(RST) |-> (ctrl_view == CTRL_RESET) && !IRQ;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("control register not zero after reset");

endmodule

// [sim/test_periodic_timebase_interrupt.sv]
`timescale 1ns/1ns
module test_periodic_timebase_interrupt;
  import pti_pkg::*;

  logic        MCLK;
  logic        RST;
  logic        PSEL;
  logic        PENABLE;
  logic        PWRITE;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA;
  logic [3:0]  PSTRB;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  logic        OSC_CLK_IN;
  logic        EXTRA_PRESCALE_SELECT;
  logic        OSCILLATOR_RUNS_IN_STOP;
  logic        WAIT_MODE;
  logic        STOP_MODE;
  logic        IRQ;
  logic        STOP_WAKEUP;
  int          n_mismatch;
  int          cmp_count;
  int          osc_cnt;
  int          base;
  int          n_wake;
  logic        osc_run;
  logic [1:0]  ph;

  pti_top dut_u
  (
    .MCLK                    (MCLK),
    .RST                     (RST),
    .PSEL                    (PSEL),
    .PENABLE                 (PENABLE),
    .PWRITE                  (PWRITE),
    .PADDR                   (PADDR),
    .PWDATA                  (PWDATA),
    .PSTRB                   (PSTRB),
    .PRDATA                  (PRDATA),
    .PREADY                  (PREADY),
    .PSLVERR                 (PSLVERR),
    .OSC_CLK_IN              (OSC_CLK_IN),
    .EXTRA_PRESCALE_SELECT   (EXTRA_PRESCALE_SELECT),
    .OSCILLATOR_RUNS_IN_STOP (OSCILLATOR_RUNS_IN_STOP),
    .WAIT_MODE               (WAIT_MODE),
    .STOP_MODE               (STOP_MODE),
    .IRQ                     (IRQ),
    .STOP_WAKEUP             (STOP_WAKEUP)
  );

  initial MCLK = 1'b0;
  always #50 MCLK = ~MCLK;

  // oscillator holds each level 4 cycles, so an event lands before the next
  // edge and the edge count at the interrupt equals the event's count
  always @(posedge MCLK)
  begin
    if (!osc_run)
    begin
      OSC_CLK_IN <= 1'b0;
      ph <= 2'h0;
    end
    else
    begin
      ph <= ph + 2'h1;
      if (ph == 2'h3)
      begin
        OSC_CLK_IN <= ~OSC_CLK_IN;
        if (!OSC_CLK_IN)
          osc_cnt <= osc_cnt + 1;
      end
    end
    if (STOP_WAKEUP === 1'b1)
      n_wake <= n_wake + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // the request is a registered level: look one edge after the write lands
  task automatic chk_irq(input logic exp, input string msg);
    @(posedge MCLK);
    chk({31'h0, IRQ}, {31'h0, exp}, msg);
  endtask

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    int n;
    n = 0;
    @(posedge MCLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    @(posedge MCLK);
    while (PREADY !== 1'b1 && n < 50)
    begin
      @(posedge MCLK);
      n++;
    end
    if (n >= 50)
    begin
      n_mismatch++;
      $display("Error at %0t: no ready from the slave", $time);
    end
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic experr);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, a, d, r, e);
    chk({31'h0, e}, {31'h0, experr}, "write error flag");
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic experr);
    logic [31:0] r;
    logic        e;
    xfer(1'b0, a, 32'h0, r, e);
    chk({31'h0, e}, {31'h0, experr}, "read error flag");
    chk(r, exp, "read data");
  endtask

  // wait for the request, then check how many oscillator counts it took
  task automatic wait_irq(input int exp);
    int n;
    n = 0;
    while (IRQ !== 1'b1 && n < 6000)
    begin
      @(posedge MCLK);
      n++;
    end
    if (n >= 6000)
    begin
      n_mismatch++;
      $display("Error at %0t: no interrupt request", $time);
    end
    chk(osc_cnt - base, exp, "event count");
  endtask

  task automatic osc_go();
    base = osc_cnt;
    osc_run <= 1'b1;
  endtask

  task automatic osc_halt();
    @(posedge MCLK);
    osc_run <= 1'b0;
    repeat (6) @(posedge MCLK);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    #4000000;
    n_mismatch++;
    conclude();
  end

  initial
  begin
    n_mismatch = 0;
    cmp_count = 0;
    osc_cnt = 0;
    base = 0;
    n_wake = 0;
    osc_run = 1'b0;
    RST = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h0;
    PWDATA = 32'h0;
    PSTRB = 4'hf;
    EXTRA_PRESCALE_SELECT = 1'b0;
    OSCILLATOR_RUNS_IN_STOP = 1'b0;
    WAIT_MODE = 1'b0;
    STOP_MODE = 1'b0;
    repeat (4) @(posedge MCLK);
    RST <= 1'b0;
    repeat (2) @(posedge MCLK);
    rd(CTRL_OFFSET, 32'h0, 1'b0);
    rd(EVT_MASK_OFFSET, 32'h0, 1'b0);
    chk({31'h0, IRQ}, 32'h0, "irq after reset");
    // field layout, ack and reserved bit read back as zero
    wr(CTRL_OFFSET, 32'h7d, 1'b0);
    rd(CTRL_OFFSET, 32'h74, 1'b0);
    // a write with byte 0 not strobed leaves the register alone
    PSTRB <= 4'h0;
    wr(CTRL_OFFSET, 32'h0, 1'b0);
    PSTRB <= 4'hf;
    rd(CTRL_OFFSET, 32'h74, 1'b0);
    wr(8'h40, 32'h1, 1'b1);
    rd(8'h40, 32'h0, 1'b1);
    // partial count, then disable must clear the chain
    wr(CTRL_OFFSET, 32'h76, 1'b0);
    osc_go();
    while (osc_cnt - base < 3) @(posedge MCLK);
    osc_halt();
    wr(CTRL_OFFSET, 32'h74, 1'b0);
    wr(CTRL_OFFSET, 32'h76, 1'b0);
    osc_go();
    wait_irq(4);
    osc_halt();
    rd(CTRL_OFFSET, 32'hf6, 1'b0);
    wr(CTRL_OFFSET, 32'h76, 1'b0);
    rd(CTRL_OFFSET, 32'hf6, 1'b0);
    chk_irq(1'b1, "irq held");
    wr(CTRL_OFFSET, 32'h7e, 1'b0);
    chk_irq(1'b0, "irq dropped");
    osc_run <= 1'b1;
    wait_irq(12);
    osc_halt();
    // each short tap: first event at half the division ratio
    for (int c = 3; c < 8; c++)
    begin
      wr(CTRL_OFFSET, 32'(c) << 4, 1'b0);
      wr(CTRL_OFFSET, (32'(c) << 4) | 32'h0e, 1'b0);
      osc_go();
      wait_irq((8 << (7 - c)) / 2);
      osc_halt();
    end
    EXTRA_PRESCALE_SELECT <= 1'b1;
    wr(CTRL_OFFSET, 32'h70, 1'b0);
    wr(CTRL_OFFSET, 32'h7e, 1'b0);
    osc_go();
    wait_irq(512);
    osc_halt();
    EXTRA_PRESCALE_SELECT <= 1'b0;
    // wait mode: register closed, counting goes on via status and mask
    wr(CTRL_OFFSET, 32'h70, 1'b0);
    wr(CTRL_OFFSET, 32'h7a, 1'b0);
    wr(EVT_STATUS_OFFSET, 32'h1, 1'b0);
    rd(EVT_STATUS_OFFSET, 32'h0, 1'b0);
    wr(EVT_MASK_OFFSET, 32'h1, 1'b0);
    WAIT_MODE <= 1'b1;
    repeat (4) @(posedge MCLK);
    rd(CTRL_OFFSET, 32'h0, 1'b1);
    wr(CTRL_OFFSET, 32'h7e, 1'b1);
    osc_go();
    wait_irq(4);
    osc_halt();
    wr(EVT_MASK_OFFSET, 32'h0, 1'b0);
    chk_irq(1'b0, "pending without enable");
    rd(EVT_STATUS_OFFSET, 32'h1, 1'b0);
    wr(EVT_STATUS_OFFSET, 32'h1, 1'b0);
    rd(EVT_STATUS_OFFSET, 32'h0, 1'b0);
    WAIT_MODE <= 1'b0;
    repeat (4) @(posedge MCLK);
    rd(CTRL_OFFSET, 32'hf2, 1'b0);
    // stop mode without the oscillator option: chain frozen
    wr(CTRL_OFFSET, 32'h70, 1'b0);
    wr(CTRL_OFFSET, 32'h7e, 1'b0);
    STOP_MODE <= 1'b1;
    repeat (4) @(posedge MCLK);
    rd(CTRL_OFFSET, 32'h0, 1'b1);
    osc_go();
    repeat (200) @(posedge MCLK);
    chk({31'h0, IRQ}, 32'h0, "frozen in stop");
    osc_halt();
    OSCILLATOR_RUNS_IN_STOP <= 1'b1;
    repeat (4) @(posedge MCLK);
    osc_go();
    wait_irq(4);
    osc_halt();
    chk({31'h0, n_wake != 0}, 32'h1, "wakeup pulse");
    wr(CTRL_OFFSET, 32'h7e, 1'b1);
    chk_irq(1'b1, "ack ignored in stop");
    STOP_MODE <= 1'b0;
    repeat (4) @(posedge MCLK);
    wr(CTRL_OFFSET, 32'h7e, 1'b0);
    chk_irq(1'b0, "irq cleared");
    conclude();
  end
endmodule
